// *** src/hpp_port.sv ***
// Host parallel port pin logic: strobes, register file, interrupt and shared status pin.
`timescale 1ns/100ps
// Contract
// - A write lands the data bus in the addressed register at the rising edge of its strobe (write or data strobe) while chip select is low.
// - The interrupt request pin is pulled low whenever an unmasked interrupt event is pending.
// - The interrupt request pin floats once every pending source has been acknowledged.
// - Mask bits exist globally and per framer, line interface unit and bit error tester; masked sources never assert.
// - Serial port select low gives the parallel bus, high gives the serial slave port only while the legacy pin function enable bit is zero.
// - Bus timing select high means data strobe with direction, low means separate read and write strobes.
// - Device reset low resets every register, framer and line interface unit.
// - The shared select pin drives status only when the legacy pin function enable bit is one.
// - As a status output, the shared pin shows line or framer signal loss, or receive signalling freeze, as the control settings choose.
// - Chip select must be low to qualify any access; strobes are ignored while it is high.
// - During a read the data bus carries the addressed register while read strobe and chip select are low.
// - The data bus is undriven whenever chip select is high.
// - Registers are selected by a thirteen-bit non-multiplexed address bus.
module hpp_port (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          device_reset_n_i,
  input  wire logic                          chip_select_n_i,
  input  wire logic                          read_strobe_n_i,
  input  wire logic                          write_strobe_n_i,
  input  wire logic                          bus_timing_select_i,
  input  wire logic [hpp_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [hpp_pkg::DATA_W-1:0]    data_i,
  output logic      [hpp_pkg::DATA_W-1:0]    data_o,
  output logic                               data_oe_o,
  input  wire logic                          serial_select_i,
  output logic                               serial_mode_o,
  output logic                               serial_select_o,
  output logic                               serial_select_oe_o,
  input  wire logic                          analog_signal_loss_i,
  input  wire logic                          framer_signal_loss_i,
  input  wire logic                          rx_signalling_freeze_i,
  input  wire logic [hpp_pkg::NUM_SRC-1:0]   irq_event_i,
  output logic                               interrupt_request_n_o,
  output logic                               interrupt_request_oe_o,
  output logic                               device_reset_o
);
  localparam int NS = hpp_pkg::NUM_SRC;
  localparam int NF = hpp_pkg::NUM_FRAMER;
  localparam int NL = hpp_pkg::NUM_LINE;

  // Register index map inside the low address bits:
  // 0 global_transceiver_ctrl, 1 global mask, 2..4 group masks, 5..7 status (write one to clear).
  localparam logic [3:0] IX_CTRL  = hpp_pkg::IX_CTRL;
  localparam logic [3:0] IX_GMASK = hpp_pkg::IX_GMASK;
  localparam logic [3:0] IX_FMASK = hpp_pkg::IX_FMASK;
  localparam logic [3:0] IX_LMASK = hpp_pkg::IX_LMASK;
  localparam logic [3:0] IX_BMASK = hpp_pkg::IX_BMASK;
  localparam logic [3:0] IX_FSTAT = hpp_pkg::IX_FSTAT;
  localparam logic [3:0] IX_LSTAT = hpp_pkg::IX_LSTAT;
  localparam logic [3:0] IX_BSTAT = hpp_pkg::IX_BSTAT;

  // Whole-device reset combines the core reset and the pin.
  wire rst_all = rst_i | ~device_reset_n_i;
  assign device_reset_o = rst_all;

  // Two-stage synchronisers for the asynchronous host pins.
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      sync3_ff <= 3'h7;
    end else begin
      sync1_ff <= {chip_select_n_i, read_strobe_n_i, write_strobe_n_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  wire cs_s    = ~sync2_ff[2];
  wire strb_s  = ~sync2_ff[1];
  wire strb_p  = ~sync3_ff[1];
  wire wr_s    = ~sync2_ff[0];
  wire wr_p    = ~sync3_ff[0];
  // The mode follows the pin only while it is an input, so a high status level cannot lock the port out.
  wire par_mode = ~serial_mode_o;
  // Strobe-and-direction style: the data strobe qualifies, the direction pin high reads and low writes.
  wire mot      = bus_timing_select_i & par_mode;
  wire wr_rise  = mot ? (strb_p & ~strb_s & wr_p)
                      : (wr_p & ~wr_s);
  wire wr_req_s = par_mode & cs_s & (mot ? (strb_s & wr_s) : wr_s);
  wire rd_req_s = par_mode & cs_s & (mot ? (strb_s & ~wr_s) : strb_s);

  // A rising strobe is only taken when its low phase was seen under chip select, and a read in
  // progress never turns into a write; this needs the synchronised strobe low one cycle before the rise, as the write state is registered from the low phase.
  hpp_pkg::hpp_state_t state_ff;
  hpp_pkg::hpp_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hpp_pkg::HPP_IDLE: begin
        if (wr_req_s) begin
          nxt_state = hpp_pkg::HPP_WRITE;
        end else if (rd_req_s) begin
          nxt_state = hpp_pkg::HPP_READ;
        end
      end
      hpp_pkg::HPP_WRITE: begin
        if (wr_rise || !cs_s || !par_mode) begin
          nxt_state = hpp_pkg::HPP_IDLE;
        end
      end
      hpp_pkg::HPP_READ: begin
        if (!rd_req_s) begin
          nxt_state = hpp_pkg::HPP_IDLE;
        end
      end
      default: begin
        nxt_state = hpp_pkg::HPP_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      state_ff <= hpp_pkg::HPP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  wire in_write  = (state_ff == hpp_pkg::HPP_WRITE);
  wire wr_commit = par_mode & cs_s & in_write & wr_rise;
  wire rd_active = par_mode & ~chip_select_n_i &
                   (mot ? (~read_strobe_n_i & write_strobe_n_i) : ~read_strobe_n_i);

  // Data and address are held stable by the host across the synchronised edge.
  logic [3:0]              wr_ix;
  logic [hpp_pkg::DATA_W-1:0] wr_data;
  assign wr_ix   = addr_i[hpp_pkg::REG_AW-1:0];
  assign wr_data = data_i;
  wire addr_hit  = (addr_i[hpp_pkg::ADDR_W-1:hpp_pkg::REG_AW] == '0);

  logic [7:0]  ctrl_ff;
  logic [7:0]  gmask_ff;
  logic [NS-1:0] mask_ff;
  logic [NS-1:0] stat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_all) begin
      ctrl_ff  <= hpp_pkg::CTRL_RESET;
      gmask_ff <= hpp_pkg::REG_RESET;
    end else if (wr_commit && addr_hit) begin
      if (wr_ix == IX_CTRL)  ctrl_ff  <= wr_data;
      if (wr_ix == IX_GMASK) gmask_ff <= wr_data;
    end
  end

  // Per-source mask and sticky status; an event in the clearing cycle survives.
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_src
      localparam logic [3:0] MIX = (g < NF) ? IX_FMASK : (g < NF + NL) ? IX_LMASK : IX_BMASK;
      localparam logic [3:0] SIX = (g < NF) ? IX_FSTAT : (g < NF + NL) ? IX_LSTAT : IX_BSTAT;
      localparam int         BIT = g % 8;
      wire wr_m = wr_commit & addr_hit & (wr_ix == MIX);
      wire clr  = wr_commit & addr_hit & (wr_ix == SIX) & wr_data[BIT];
      always_ff @(posedge clk_i) begin
        if (rst_all) begin
          mask_ff[g] <= 1'b1;
          stat_ff[g] <= 1'b0;
        end else begin
          if (wr_m) mask_ff[g] <= wr_data[BIT];
          stat_ff[g] <= irq_event_i[g] | (stat_ff[g] & ~clr);
        end
      end
    end
  endgenerate

  // Global mask bits 0..2 block the framer, line interface and tester groups; bit 7 blocks all.
  wire [NS-1:0] grp_blk = {{(NS-NF-NL){gmask_ff[2]}}, {NL{gmask_ff[1]}}, {NF{gmask_ff[0]}}};
  wire          irq_any = |(stat_ff & ~mask_ff & ~grp_blk) & ~gmask_ff[7];
  logic irq_ff;
  always_ff @(posedge clk_i) begin
    if (rst_all) irq_ff <= 1'b0;
    else         irq_ff <= irq_any;
  end
  assign interrupt_request_n_o  = 1'b0;
  assign interrupt_request_oe_o = irq_ff;

  // Read data mux.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (addr_hit) begin
      case (wr_ix)
        IX_CTRL:  rd_mux = ctrl_ff;
        IX_GMASK: rd_mux = gmask_ff;
        IX_FMASK: rd_mux = mask_ff[NF-1:0];
        IX_LMASK: rd_mux = mask_ff[NF+NL-1:NF];
        IX_BMASK: rd_mux = mask_ff[NS-1:NF+NL];
        IX_FSTAT: rd_mux = stat_ff[NF-1:0];
        IX_LSTAT: rd_mux = stat_ff[NF+NL-1:NF];
        IX_BSTAT: rd_mux = stat_ff[NS-1:NF+NL];
        default:  rd_mux = 8'h00;
      endcase
    end
  end
  logic [7:0] rdata_ff;
  always_ff @(posedge clk_i) begin
    if (rst_all) rdata_ff <= 8'h00;
    else         rdata_ff <= rd_mux;
  end
  assign data_o    = rdata_ff;
  assign data_oe_o = rd_active & ~rst_all;

  // Shared pin: input select unless the legacy function turns it into a status output.
  wire legacy = ctrl_ff[hpp_pkg::LEGACY_BIT];
  wire los_v  = ctrl_ff[hpp_pkg::LOS_SEL_BIT] ? framer_signal_loss_i : analog_signal_loss_i;
  logic status_ff;
  always_ff @(posedge clk_i) begin
    if (rst_all) status_ff <= 1'b0;
    else         status_ff <= ctrl_ff[hpp_pkg::FRZ_SEL_BIT] ? rx_signalling_freeze_i : los_v;
  end
  assign serial_select_o    = status_ff;
  assign serial_select_oe_o = legacy;
  // Once the pin is an output its level no longer picks the mode.
  assign serial_mode_o      = serial_select_i & ~legacy;
endmodule // hpp_port

// *** pkg/hpp_pkg.sv ***
// Package with constants and types for the host processor port pins block.
package hpp_pkg;
  localparam int ADDR_W      = 13;
  localparam int DATA_W      = 8;
  localparam int NUM_FRAMER  = 8;
  localparam int NUM_LINE    = 8;
  localparam int NUM_TESTER  = 8;
  localparam int NUM_SRC     = NUM_FRAMER + NUM_LINE + NUM_TESTER;
  localparam int NUM_REGS    = 16;
  localparam int REG_AW      = 4;
  // Register indices within the low address bits.
  localparam logic [3:0] IX_CTRL  = 4'h0;
  localparam logic [3:0] IX_GMASK = 4'h1;
  localparam logic [3:0] IX_FMASK = 4'h2;
  localparam logic [3:0] IX_LMASK = 4'h3;
  localparam logic [3:0] IX_BMASK = 4'h4;
  localparam logic [3:0] IX_FSTAT = 4'h5;
  localparam logic [3:0] IX_LSTAT = 4'h6;
  localparam logic [3:0] IX_BSTAT = 4'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int LEGACY_BIT  = 0;
  localparam int LOS_SEL_BIT = 1;
  localparam int FRZ_SEL_BIT = 2;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  typedef enum logic [2:0] {
    HPP_IDLE  = 3'b001,
    HPP_WRITE = 3'b010,
    HPP_READ  = 3'b100
  } hpp_state_t;
endpackage : hpp_pkg

// *** dv/hpp_port_chk.sv ***
// Checker of the parallel host port pin behaviour, bound to the port block.
`timescale 1ns/100ps
module hpp_port_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        device_reset_n_i,
  input wire logic        chip_select_n_i,
  input wire logic        read_strobe_n_i,
  input wire logic        serial_select_i,
  input wire logic [12:0] addr_i,
  input wire logic [7:0]  data_o,
  input wire logic        data_oe_o,
  input wire logic        serial_mode_o,
  input wire logic        serial_select_oe_o,
  input wire logic        interrupt_request_n_o,
  input wire logic        interrupt_request_oe_o,
  input wire logic        device_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_dev_rst; !device_reset_n_i; endsequence
  chk_cs_release: assert property (chip_select_n_i |-> !data_oe_o) else $error("bus driven while deselected");
  chk_read_qual: assert property (data_oe_o |-> !read_strobe_n_i && !serial_mode_o) else $error("bad drive");
  chk_mode_decode: assert property (serial_mode_o == (serial_select_i && !serial_select_oe_o)) else $error("mode");
  chk_irq_low: assert property (interrupt_request_n_o == 1'h0) else $error("irq pin level wrong");
  chk_rst_quiet: assert property (s_dev_rst |=> !interrupt_request_oe_o && !serial_select_oe_o) else $error("rst");
  chk_rst_join: assert property (s_dev_rst |-> device_reset_o) else $error("device reset not combined");
  chk_rst_bus: assert property (s_dev_rst |-> !data_oe_o) else $error("bus driven in reset");
  chk_unmapped_zero: assert property ($past(addr_i[12:4]) != 9'h000 |-> data_o == 8'h00) else $error("hit");
endmodule // hpp_port_chk
bind hpp_port hpp_port_chk u_hpp_port_chk (.*);

// *** dv/hpp_host.sv ***
// Host bus master model for the parallel port in both strobe timing styles.
`timescale 1ns/100ps
module hpp_host (
  input  wire logic        clk_i,
  input  wire logic [7:0]  data_o,
  input  wire logic        data_oe_o,
  output logic             chip_select_n_i,
  output logic             read_strobe_n_i,
  output logic             write_strobe_n_i,
  output logic             bus_timing_select_i,
  output logic [12:0]      addr_i,
  output logic [7:0]       data_i
);
  initial begin
    {chip_select_n_i, read_strobe_n_i, write_strobe_n_i, bus_timing_select_i} = 4'hE;
    addr_i = 13'h0000;
    data_i = 8'h00;
  end
  // Strobe held 3 cycles and address 4 more, since the port synchronises the pins first.
  task automatic acc(input bit mot, wr, cs_n, input logic [12:0] a, inout logic [7:0] d);
    @(posedge clk_i);
    #1;
    bus_timing_select_i = mot;
    chip_select_n_i = cs_n;
    addr_i = a;
    data_i = d;
    write_strobe_n_i = !wr;
    read_strobe_n_i = !(mot || !wr);
    repeat (3) @(posedge clk_i);
    #1;
    // An undriven bus reads back as the inverse of the port's register, so a missing enable is caught.
    if (!wr) d = data_oe_o ? data_o : ~data_o;
    read_strobe_n_i = 1'h1;
    if (!mot) write_strobe_n_i = 1'h1;
    repeat (4) @(posedge clk_i);
    #1;
    {chip_select_n_i, write_strobe_n_i} = 2'h3;
    // A released bus shows the inverse, so stale data can never pass for a match.
    data_i = ~d;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
endmodule // hpp_host

// *** dv/hpp_port_bench.sv ***
// Self-checking bench of the parallel host port pin block.
`timescale 1ns/100ps
module hpp_port_bench;
  logic clk_i = 1'h0, rst_i = 1'h1, device_reset_n_i = 1'h1, sel_pin = 1'h0;
  logic analog_signal_loss_i = 1'h0, framer_signal_loss_i = 1'h0, rx_signalling_freeze_i = 1'h0;
  logic [23:0] irq_event_i = 24'h000000;
  logic chip_select_n_i, read_strobe_n_i, write_strobe_n_i, bus_timing_select_i, data_oe_o, serial_mode_o;
  logic serial_select_o, serial_select_oe_o, interrupt_request_n_o, interrupt_request_oe_o, device_reset_o;
  logic [12:0] addr_i;
  logic [7:0]  data_i, data_o;
  int          err_total = 0, comparisons = 0;
  wire         serial_select_i = serial_select_oe_o ? serial_select_o : sel_pin;
  hpp_port u_hpp_port (.*);
  hpp_host u_hpp_host (.*);
  always #5 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input bit m, input logic [12:0] a, input logic [7:0] v);
    u_hpp_host.acc(m, 1'b1, 1'b0, a, v);
  endtask
  task automatic rchk(input bit m, input logic [12:0] a, input logic [7:0] e);
    logic [7:0] d;
    d = 8'h00;
    u_hpp_host.acc(m, 1'b0, 1'b0, a, d);
    chk(d, e);
  endtask
  task automatic pulse(input int b);
    @(posedge clk_i) #1 irq_event_i[b] = 1'h1;
    @(posedge clk_i) #1 irq_event_i[b] = 1'h0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic t_bus;
    logic [7:0] v;
    v = 8'h66;
    w(0, 13'h0002, 8'hA5);
    rchk(0, 13'h0002, 8'hA5);
    w(1, 13'h0003, 8'h3C);
    rchk(1, 13'h0003, 8'h3C);
    u_hpp_host.acc(0, 1, 1, 13'h0002, v);
    rchk(0, 13'h0002, 8'hA5);
    w(0, 13'h0012, 8'h77);
    rchk(0, 13'h0012, 8'h00);
    chk({7'h00, data_oe_o}, 8'h00);
    $display("bus test done");
  endtask
  task automatic t_irq;
    w(0, 13'h0001, 8'h00);
    w(0, 13'h0004, 8'hFE);
    pulse(17);
    chk({7'h00, interrupt_request_oe_o}, 8'h00);
    pulse(16);
    chk({7'h00, interrupt_request_oe_o}, 8'h01);
    w(0, 13'h0001, 8'h80);
    chk({7'h00, interrupt_request_oe_o}, 8'h00);
    w(0, 13'h0001, 8'h04);
    chk({7'h00, interrupt_request_oe_o}, 8'h00);
    w(0, 13'h0001, 8'h00);
    chk({7'h00, interrupt_request_oe_o}, 8'h01);
    w(0, 13'h0007, 8'h01);
    chk({7'h00, interrupt_request_oe_o}, 8'h00);
    $display("interrupt test done");
  endtask
  task automatic t_pin;
    analog_signal_loss_i = 1'h1;
    w(0, 13'h0000, 8'h01);
    chk({6'h00, serial_select_oe_o, serial_select_o}, 8'h03);
    w(0, 13'h0000, 8'h03);
    chk({6'h00, serial_select_oe_o, serial_select_o}, 8'h02);
    rx_signalling_freeze_i = 1'h1;
    w(0, 13'h0000, 8'h07);
    chk({6'h00, serial_select_oe_o, serial_select_o}, 8'h03);
    w(0, 13'h0000, 8'h00);
    sel_pin = 1'h1;
    w(0, 13'h0002, 8'h11);
    chk({7'h00, serial_mode_o}, 8'h01);
    sel_pin = 1'h0;
    rchk(0, 13'h0002, 8'hA5);
    $display("pin test done");
  endtask
  task automatic t_rst;
    @(posedge clk_i) #1 device_reset_n_i = 1'h0;
    repeat (2) @(posedge clk_i);
    #1 device_reset_n_i = 1'h1;
    rchk(0, 13'h0002, 8'hFF);
    $display("reset test done");
  endtask
  task automatic close_out;
    $display("Counts: %0d mismatches, %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'h0;
    t_bus();
    t_irq();
    t_pin();
    t_rst();
    close_out();
  end
endmodule // hpp_port_bench
